// *** bench/adc_model.sv ***
// adc stand-in answering conversion starts of the measurement path
// assumes the clock of the path; the bench sets the sample of each channel
`timescale 1ns/1ps
`default_nettype none
module adc_model (
  input wire logic i_clk,
  input wire logic i_start,
  input wire logic [1:0] i_chan,
  input wire logic [19:0] i_temp,
  input wire logic [19:0] i_press,
  input wire logic [19:0] i_hum,
  output logic [19:0] o_data,
  output logic o_done
);
  int wait_cnt = -1;
  logic slow = 1'b0;
  logic [1:0] chan = 2'h0;
  logic [19:0] data_q = 20'h5a5a5;
  logic done_q = 1'b0;
  assign o_data = data_q;
  assign o_done = done_q;
  // quick and slow conversions alternate; data inverted each cycle outside done so stale values match only on alternate cycles
  always @(posedge i_clk) begin
    done_q <= 1'b0;
    data_q <= ~data_q;
    if (i_start) begin
      chan <= i_chan;
      wait_cnt <= slow ? 6 : 1;
      slow <= ~slow;
    end else if (wait_cnt == 0) begin
      done_q <= 1'b1;
      data_q <= (chan == 2'h0) ? i_temp : (chan == 2'h1) ? i_press : i_hum;
      wait_cnt <= -1;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench of the pressure/temperature path
// assumes the adc model on the far side and a short standby count
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [19:0] adc_data, rdata, rv;
  logic adc_done, adc_start, measuring;
  logic [1:0] adc_chan;
  logic [19:0] t_smp = 20'h0, p_smp = 20'h0, h_smp = 20'h0;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  press_temp_path #(.STANDBY_CYCLES(4)) u_press_temp_path (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_adc_data(adc_data), .i_adc_done(adc_done), .o_rdata(rdata),
    .o_adc_start(adc_start), .o_adc_chan(adc_chan), .o_measuring(measuring));
  adc_model u_adc_model (.i_clk(i_clk), .i_start(adc_start), .i_chan(adc_chan), .i_temp(t_smp),
    .i_press(p_smp), .i_hum(h_smp), .o_data(adc_data), .o_done(adc_done));
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  // ****************************************
  // bus tasks and comparison
  // ****************************************
  task automatic check(input string name, input logic [19:0] exp, input logic [19:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [19:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = rdata;
  endtask
  // polled at the falling edge so the level is settled; bounded since a stuck sequencer must not hang the run
  task automatic wait_meas(input logic lvl);
    int k;
    k = 0;
    while (measuring !== lvl && k < 200) begin
      @(negedge i_clk);
      k++;
    end
    if (k == 200) check("measuring", {19'h0, lvl}, {19'h0, ~lvl});
  endtask
  // one forced period
  task automatic measure(input logic [7:0] ctrl, input logic [19:0] t, input logic [19:0] p, input logic [19:0] h);
    t_smp = t;
    p_smp = p;
    h_smp = h;
    wr(press_temp_pkg::ADDR_CTRL_MEAS, ctrl);
    wait_meas(1'b1);
    wait_meas(1'b0);
    repeat (2) @(posedge i_clk);
  endtask
  task automatic expect_tp(input logic [19:0] et, input logic [19:0] ep);
    rd(press_temp_pkg::ADDR_TEMP, rv);
    check("temperature", et, rv);
    rd(press_temp_pkg::ADDR_PRESS, rv);
    check("pressure", ep, rv);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_resolution;
    logic [2:0] os;
    wr(press_temp_pkg::ADDR_CONFIG, 8'h00);
    for (int i = 1; i <= 5; i++) begin
      os = i[2:0];
      measure({os, os, 2'b01}, 20'hfffff, 20'hfffff, 20'h1234f);
      expect_tp(20'hfffff << (5 - i), 20'hfffff << (5 - i));
    end
    rd(press_temp_pkg::ADDR_HUM, rv);
    check("humidity", 20'h01234, rv);
    measure(8'h21, 20'h12345, 20'h54321, 20'h5678f);
    expect_tp(20'h12340, 20'h80000);
    rd(press_temp_pkg::ADDR_HUM, rv);
    check("humidity", 20'h05678, rv);
  endtask
  task automatic t_coeff;
    for (int f = 1; f <= 4; f++) begin
      wr(press_temp_pkg::ADDR_CONFIG, 8'(f << 2));
      measure(8'h25, 20'h00000, 20'h10000, 20'h0);
      expect_tp(20'h00000, 20'h10000);
      measure(8'h25, 20'hffff0, 20'h00000, 20'habcd0);
      expect_tp(20'hffff0 >> f, 20'h10000 - (20'h10000 >> f));
      rd(press_temp_pkg::ADDR_HUM, rv);
      check("humidity", 20'h0abcd, rv);
    end
  endtask
  task automatic t_skip;
    wr(press_temp_pkg::ADDR_CONFIG, 8'h04);
    measure(8'h25, 20'h40000, 20'h40000, 20'h0);
    expect_tp(20'h40000, 20'h40000);
    measure(8'h01, 20'h00000, 20'h00000, 20'h0);
    expect_tp(20'h80000, 20'h80000);
    measure(8'h25, 20'h00000, 20'h00000, 20'h0);
    expect_tp(20'h20000, 20'h20000);
    wr(press_temp_pkg::ADDR_CONFIG, 8'h04);
    measure(8'h25, 20'h00000, 20'h00000, 20'h0);
    expect_tp(20'h00000, 20'h00000);
    rd(press_temp_pkg::ADDR_CTRL_MEAS, rv);
    check("mode after forced", 20'h00024, rv);
  endtask
  // normal mode: two periods with k16; sleep is written before a third period can start
  task automatic t_normal;
    wr(press_temp_pkg::ADDR_CONFIG, 8'h10);
    t_smp = 20'h10000;
    p_smp = 20'h20000;
    wr(press_temp_pkg::ADDR_CTRL_MEAS, 8'h57);
    wait_meas(1'b1);
    wait_meas(1'b0);
    t_smp = 20'h00000;
    p_smp = 20'h30000;
    expect_tp(20'h10000, 20'h20000);
    wait_meas(1'b1);
    wait_meas(1'b0);
    wr(press_temp_pkg::ADDR_CTRL_MEAS, 8'h54);
    expect_tp(20'h0f000, 20'h21000);
  endtask
  task automatic t_unmapped;
    wr(4'hf, 8'hff);
    rd(4'hf, rv);
    check("unmapped read", 20'h0, rv);
    rd(press_temp_pkg::ADDR_STATUS, rv);
    check("status", 20'h0, rv);
    rd(press_temp_pkg::ADDR_CONFIG, rv);
    check("config", 20'h00010, rv);
  endtask
  task automatic stop_test;
    $display("mismatches %0d n_checks %0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // whole run needs well under two thousand cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("unexpected timeout: expected end seen hang");
      stop_test();
    end
  end
  initial begin
    repeat (10) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk);
    wr(press_temp_pkg::ADDR_CTRL_HUM, 8'h01);
    t_resolution();
    t_coeff();
    t_skip();
    t_normal();
    t_unmapped();
    stop_test();
  end
endmodule
`default_nettype wire

// *** rtl/iir_channel.sv ***
// one channel of the first order iir low pass filter
// assumes sample and settings from the same clock; result one cycle later
`timescale 1ns/1ps
`default_nettype none
module iir_channel (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_flush,
  input wire logic i_go,
  input wire logic [2:0] i_os,
  input wire logic [2:0] i_filt,
  input wire logic [19:0] i_sample,
  output logic [19:0] o_result
);
  typedef struct packed {
    logic [19:0] mem;
    logic primed;
    logic [19:0] result;
  } ch_state_t;
  ch_state_t s_reg, s_next;
  logic [23:0] acc;
  logic [19:0] trunc;
  logic [2:0] shift;
  always_comb begin
    s_next = s_reg;
    shift = (i_filt > 3'h4) ? 3'h4 : i_filt;
    acc = ({4'h0, s_reg.mem} << shift) - {4'h0, s_reg.mem} + {4'h0, i_sample};
    // filter off keeps 16+os-1 bits, the low bits read as zero
    // shift kept at five bits: a three bit sum would wrap the base of sixteen to zero
    trunc = i_sample & ~(20'hfffff >> (5'(press_temp_pkg::RES_BASE) + 5'(i_os) - 5'h1));
    if (i_flush) begin
      s_next.primed = 1'b0;
    end
    if (i_go) begin
      if (i_os == 3'h0) begin
        s_next.result = press_temp_pkg::SKIP_VALUE;
      end else if (i_filt == 3'h0) begin
        s_next.result = trunc;
      end else if (!s_reg.primed) begin
        s_next.mem = i_sample;
        s_next.result = i_sample;
        s_next.primed = 1'b1;
      end else begin
        s_next.mem = 20'(acc >> shift);
        s_next.result = 20'(acc >> shift);
      end
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign o_result = s_reg.result;
  skip_mark_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_go && i_os == 3'h0) |=> (o_result == 20'h80000 && $stable(s_reg.mem))) else $error("skip");
  bypass_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_go && i_os != 3'h0 && i_filt != 3'h0 && !s_reg.primed) |=> o_result == $past(i_sample))
    else $error("bypass");
endmodule
`default_nettype wire

// *** rtl/press_temp_path.sv ***
// pressure/temperature measurement path: sequencer, registers and two iir channels
// assumes adc samples arrive as plain inputs with a strobe per conversion
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module press_temp_path #(
  parameter int STANDBY_CYCLES = press_temp_pkg::STANDBY_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [19:0] i_adc_data,
  input wire logic i_adc_done,
  output logic [19:0] o_rdata,
  output logic o_adc_start,
  output logic [1:0] o_adc_chan,
  output logic o_measuring
);
  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rst_sync;
  logic rst;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst = !rst_sync[1];

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] ctrl_meas;
    logic [7:0] ctrl_hum;
    logic [7:0] config_r;
    press_temp_pkg::seq_t seq;
    logic [19:0] t_raw;
    logic [19:0] p_raw;
    logic [15:0] hum;
    logic [31:0] wait_cnt;
    logic [19:0] rdata;
    logic adc_start;
    logic [1:0] adc_chan;
    logic measuring;
    logic flush;
    logic go;
  } top_state_t;
  top_state_t s_reg, s_next;
  logic [19:0] press_res, temp_res;
  logic [2:0] osp, ost, osh, filt;
  logic [1:0] mode;

  assign osp = s_reg.ctrl_meas[press_temp_pkg::OSP_LSB +: 3];
  assign ost = s_reg.ctrl_meas[press_temp_pkg::OST_LSB +: 3];
  assign osh = s_reg.ctrl_hum[2:0];
  assign mode = s_reg.ctrl_meas[press_temp_pkg::MODE_LSB +: 2];
  assign filt = s_reg.config_r[press_temp_pkg::FILT_LSB +: 3];

  // ****************************************
  // sequencer and register port
  // ****************************************
  always_comb begin
    s_next = s_reg;
    s_next.adc_start = 1'b0;
    s_next.flush = 1'b0;
    s_next.go = 1'b0;
    s_next.rdata = 20'h0;
    if (i_wr) begin
      unique case (i_addr)
        press_temp_pkg::ADDR_CTRL_MEAS: s_next.ctrl_meas = i_wdata;
        press_temp_pkg::ADDR_CTRL_HUM: s_next.ctrl_hum = i_wdata;
        press_temp_pkg::ADDR_CONFIG: begin
          s_next.config_r = i_wdata;
          s_next.flush = 1'b1;
        end
        default: ;
      endcase
    end
    if (i_rd) begin
      unique case (i_addr)
        press_temp_pkg::ADDR_CTRL_MEAS: s_next.rdata = {12'h0, s_reg.ctrl_meas};
        press_temp_pkg::ADDR_CTRL_HUM: s_next.rdata = {12'h0, s_reg.ctrl_hum};
        press_temp_pkg::ADDR_CONFIG: s_next.rdata = {12'h0, s_reg.config_r};
        press_temp_pkg::ADDR_STATUS: s_next.rdata = {19'h0, s_reg.measuring};
        press_temp_pkg::ADDR_PRESS: s_next.rdata = press_res;
        press_temp_pkg::ADDR_TEMP: s_next.rdata = temp_res;
        press_temp_pkg::ADDR_HUM: s_next.rdata = {4'h0, s_reg.hum};
        default: s_next.rdata = 20'h0;
      endcase
    end
    unique case (s_reg.seq)
      press_temp_pkg::ST_IDLE: begin
        if (mode != press_temp_pkg::MODE_SLEEP) begin
          s_next.seq = press_temp_pkg::ST_TEMP;
          s_next.measuring = 1'b1;
          s_next.adc_start = (ost != 3'h0);
          s_next.adc_chan = 2'h0;
        end
      end
      press_temp_pkg::ST_TEMP: begin
        if (ost == 3'h0 || i_adc_done) begin
          s_next.t_raw = i_adc_data;
          s_next.seq = press_temp_pkg::ST_PRESS;
          s_next.adc_start = (osp != 3'h0);
          s_next.adc_chan = 2'h1;
        end
      end
      press_temp_pkg::ST_PRESS: begin
        if (osp == 3'h0 || i_adc_done) begin
          s_next.p_raw = i_adc_data;
          s_next.seq = press_temp_pkg::ST_HUM;
          s_next.adc_start = (osh != 3'h0);
          s_next.adc_chan = 2'h2;
        end
      end
      press_temp_pkg::ST_HUM: begin
        if (osh == 3'h0 || i_adc_done) begin
          s_next.hum = (osh == 3'h0) ? press_temp_pkg::HUM_SKIP_VALUE : i_adc_data[19:4];
          s_next.seq = press_temp_pkg::ST_FILT;
          s_next.go = 1'b1;
        end
      end
      press_temp_pkg::ST_FILT: begin
        s_next.measuring = 1'b0;
        s_next.wait_cnt = 32'h0;
        if (mode == press_temp_pkg::MODE_NORMAL) begin
          s_next.seq = press_temp_pkg::ST_STBY;
        end else begin
          // forced mode drops back to sleep after one period
          s_next.ctrl_meas[press_temp_pkg::MODE_LSB +: 2] = press_temp_pkg::MODE_SLEEP;
          s_next.seq = press_temp_pkg::ST_IDLE;
        end
      end
      press_temp_pkg::ST_STBY: begin
        s_next.wait_cnt = s_reg.wait_cnt + 32'h1;
        if (s_reg.wait_cnt >= 32'(STANDBY_CYCLES - 1)) begin
          s_next.seq = press_temp_pkg::ST_IDLE;
        end
      end
      default: s_next.seq = press_temp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.ctrl_meas <= press_temp_pkg::CTRL_MEAS_RST;
      s_reg.ctrl_hum <= press_temp_pkg::CTRL_HUM_RST;
      s_reg.config_r <= press_temp_pkg::CONFIG_RST;
      s_reg.seq <= press_temp_pkg::ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // filter channels
  // ****************************************
  // each channel keeps its own memory so skipping one never disturbs the other
  iir_channel u_temp (
    .i_clk(i_clk),
    .i_rst(rst),
    .i_flush(s_reg.flush),
    .i_go(s_reg.go),
    .i_os(ost),
    .i_filt(filt),
    .i_sample(s_reg.t_raw),
    .o_result(temp_res)
  );
  iir_channel u_press (
    .i_clk(i_clk),
    .i_rst(rst),
    .i_flush(s_reg.flush),
    .i_go(s_reg.go),
    .i_os(osp),
    .i_filt(filt),
    .i_sample(s_reg.p_raw),
    .o_result(press_res)
  );

  assign o_rdata = s_reg.rdata;
  assign o_adc_start = s_reg.adc_start;
  assign o_adc_chan = s_reg.adc_chan;
  assign o_measuring = s_reg.measuring;

  // ****************************************
  // checks
  // ****************************************
  press_skip_a: assert property (@(posedge i_clk) disable iff (rst)
    (s_reg.go && osp == 3'h0) |=> ##1 press_res == 20'h80000) else $error("pressure skip value");
  cfg_flush_a: assert property (@(posedge i_clk) disable iff (rst)
    (i_wr && i_addr == press_temp_pkg::ADDR_CONFIG) |=> s_reg.flush) else $error("config write no flush");
  forced_sleep_a: assert property (@(posedge i_clk) disable iff (rst)
    (s_reg.seq == press_temp_pkg::ST_FILT && mode == press_temp_pkg::MODE_FORCED && !i_wr)
    |=> mode == press_temp_pkg::MODE_SLEEP) else $error("forced no sleep");
  order_a: assert property (@(posedge i_clk) disable iff (rst)
    (s_reg.seq == press_temp_pkg::ST_TEMP) |=> s_reg.seq inside {press_temp_pkg::ST_TEMP, press_temp_pkg::ST_PRESS})
    else $error("order");
  temp_skip_a: assert property (@(posedge i_clk) disable iff (rst)
    (s_reg.go && ost == 3'h0) |=> ##1 temp_res == 20'h80000) else $error("temperature skip value");
  read_lat_a: assert property (@(posedge i_clk) disable iff (rst)
    (i_rd && i_addr == press_temp_pkg::ADDR_STATUS) |=> o_rdata == {19'h0, $past(s_reg.measuring)})
    else $error("status read");
  no_start_skip_a: assert property (@(posedge i_clk) disable iff (rst)
    (s_reg.seq == press_temp_pkg::ST_IDLE && mode != 2'h0 && ost == 3'h0) |=> !o_adc_start)
    else $error("skipped temperature converted");
  hum_unfilt_a: assert property (@(posedge i_clk) disable iff (rst)
    (s_reg.seq == press_temp_pkg::ST_HUM && i_adc_done && osh != 3'h0) |=> {4'h0, s_reg.hum} == ($past(i_adc_data) >> 4))
    else $error("humidity altered");
endmodule
`default_nettype wire

// *** rtl/press_temp_pkg.sv ***
// constants of the pressure/temperature output path with its iir filter
// assumes a host that writes settings over a plain register port
//
// Function
// - pressure measured or skipped by its oversampling
// - pressure twenty bits when filter enabled
// - filter off: pressure sixteen plus setting minus one
// - temperature measured or skipped by its oversampling
// - temperature twenty bits when filter enabled
// - filter off: temperature sixteen plus setting minus one
// - separate filter memory per channel
// - new equals old times (k-1) plus sample, over k
// - filtered value updates memory and result
// - coefficient off, 2, 4, 8 or 16
// - filter config write resets both channels
// - first sample after reset bypasses, seeds memory
// - skipped channel keeps its filter memory
// - skipped channel result reads 0x80000
// - re-enabled channel filters against retained memory
// - humidity never filtered
// - temperature, pressure, humidity order; filter after period
// - single shot measures once then sleeps
// - humidity result fixed sixteen bits
package press_temp_pkg;
  localparam logic [3:0] ADDR_CTRL_MEAS = 4'h0;
  localparam logic [3:0] ADDR_CTRL_HUM = 4'h1;
  localparam logic [3:0] ADDR_CONFIG = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_PRESS = 4'h4;
  localparam logic [3:0] ADDR_TEMP = 4'h5;
  localparam logic [3:0] ADDR_HUM = 4'h6;
  // ctrl_meas fields: [1:0] mode, [4:2] pressure os, [7:5] temperature os
  localparam int MODE_LSB = 0;
  localparam int OSP_LSB = 2;
  localparam int OST_LSB = 5;
  // config fields: [4:2] filter select, [7:5] standby select
  localparam int FILT_LSB = 2;
  localparam int SB_LSB = 5;
  localparam logic [7:0] CTRL_MEAS_RST = 8'h00;
  localparam logic [7:0] CTRL_HUM_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [19:0] SKIP_VALUE = 20'h80000;
  localparam logic [15:0] HUM_SKIP_VALUE = 16'h8000;
  localparam int RES_FULL = 20;
  localparam int RES_BASE = 16;
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_FORCED = 2'h1;
  localparam logic [1:0] MODE_NORMAL = 2'h3;
  // standby 0.5 ms in ns, and its cycle count at 200 MHz
  localparam int CLK_PERIOD_NS = 5;
  localparam int STANDBY_MIN_NS = 500000;
  localparam int STANDBY_CYC = STANDBY_MIN_NS / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TEMP = 3'b001,
    ST_PRESS = 3'b011,
    ST_HUM = 3'b010,
    ST_FILT = 3'b110,
    ST_STBY = 3'b100
  } seq_t;
endpackage
